// >>> core/clbi_bus_if.sv
// Processor-side local bus interface: cycles, holds, inquiries, flush, errors.
`timescale 1ns/1ps
`include "clbi_defs.svh"
module clbi_bus_if
  import clbi_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Core request side.
  input wire clbi_req_t req_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  output clbi_data_t rd_data_out,
  output logic rd_valid_out,
  output logic rd_par_err_out,
  // Cycle control pins.
  output logic addr_strobe_n_out,
  output logic cycle_pending_req_out,
  output logic cache_flag_n_out,
  output logic data_code_out,
  output logic write_read_out,
  input wire logic xfer_done_n_in,
  input wire logic xfer_done_alt_n_in,
  input wire logic fill_allow_n_in,
  input wire logic ext_wbuf_empty_n_in,
  // Address pins, three signals each way.
  output logic [`CLBI_ADDR_W-1:0] line_addr_lines_out,
  output logic line_addr_lines_oe_out,
  input wire logic [`CLBI_ADDR_W-1:0] line_addr_lines_in,
  output logic addr_parity_out,
  input wire logic addr_parity_in,
  input wire logic addr_float_req_in,
  // Data pins.
  output clbi_data_t data_lines_out,
  output logic data_lines_oe_out,
  input wire clbi_data_t data_lines_in,
  input wire logic data_float_req_in,
  input wire logic scatter_enable_in,
  // Hold arbitration.
  input wire logic hold_req_in,
  output logic hold_ack_out,
  // Inquiry.
  input wire logic snoop_strobe_n_in,
  input wire logic snoop_invalidate_in,
  input wire logic snoop_line_valid_in,
  input wire logic snoop_line_dirty_in,
  output logic snoop_hit_n_out,
  output logic snoop_hit_dirty_n_out,
  output logic snoop_set_invalid_out,
  output logic snoop_set_shared_out,
  input wire logic snoop_done_in,
  // Strap, flush, errors, interrupt.
  input wire logic core_ratio_sel_in,
  output logic [1:0] core_ratio_out,
  input wire logic flush_n_in,
  output logic flush_busy_out,
  input wire logic fp_fault_in,
  input wire logic fp_fault_unmasked_in,
  output logic fp_error_n_out,
  input wire logic fp_error_ignore_n_in,
  output logic fp_stall_out,
  input wire logic maskable_irq_in,
  input wire logic irq_enable_flag_in,
  output logic irq_take_out
);
  typedef struct packed {
    clbi_bus_st_t bus;
    clbi_req_t cur;
    logic burst;
    logic [2:0] beats;
    logic first_done;
    logic ratio_caught;
    logic [1:0] ratio;
    logic rst_seen;
    logic addr_off;
    logic data_off;
    logic wbuf_block;
    logic [1:0] snp_pipe;
    clbi_snoop_t snp;
    logic hit_n;
    logic dirty_n;
    logic set_inv;
    logic set_shr;
    logic [7:0] flush_cnt;
    logic fp_error_n_n;
    logic stall;
    logic fbusy;
    logic irq;
    logic ads_n;
    logic cycle_pending_req;
    logic cache_n;
    logic dc;
    logic wr;
    logic hold_ack;
    clbi_data_t rdat;
    logic rvalid;
    logic perr;
  } clbi_st_t;

  clbi_st_t st_r;
  clbi_st_t st_nxt;
  clbi_req_t q_req;
  logic q_valid;
  logic q_pop;
  logic done;

  // Parity per byte: even count of ones across each byte plus its bit.
  function automatic logic [`CLBI_BYTES-1:0] byte_par(
    input logic [`CLBI_DATA_W-1:0] d);
    logic [`CLBI_BYTES-1:0] p;
    p = '0;
    for (int i = 0; i < `CLBI_BYTES; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction

  clbi_fifo #(
    .WIDTH($bits(clbi_req_t)),
    .DEPTH(`CLBI_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .wr_data_in(req_in),
    .wr_valid_in(req_valid_in),
    .wr_ready_out(req_ready_out),
    .rd_data_out(q_req),
    .rd_valid_out(q_valid),
    .rd_ready_in(q_pop)
  );

  assign done = !(xfer_done_n_in && xfer_done_alt_n_in);

  // A write to an owned line waits behind a non-empty external buffer.
  assign q_pop = q_valid && !hold_req_in && !st_r.hold_ack &&
                 (st_r.bus == CLBI_IDLE) &&
                 !(q_req.write && q_req.line_excl && st_r.wbuf_block);

  always_comb begin
    st_nxt = st_r;
    st_nxt.ads_n = 1'b1;
    st_nxt.rvalid = 1'b0;
    st_nxt.perr = 1'b0;
    // The strap is taken on the first enabled edge after release.
    if (!st_r.ratio_caught) begin
      st_nxt.ratio_caught = 1'b1;
      st_nxt.ratio = core_ratio_sel_in ? `CLBI_RATIO_3X
                                       : `CLBI_RATIO_2X;
    end
    st_nxt.addr_off = addr_float_req_in;
    st_nxt.data_off = data_float_req_in && scatter_enable_in;
    st_nxt.hold_ack = hold_req_in && (st_r.bus == CLBI_IDLE);
    case (st_r.bus)
      CLBI_IDLE: begin
        if (q_pop) begin
          st_nxt.bus = CLBI_ADDR;
          st_nxt.cur = q_req;
          st_nxt.ads_n = 1'b0;
          st_nxt.cycle_pending_req = 1'b1;
          st_nxt.dc = q_req.data_acc;
          st_nxt.wr = q_req.write;
          st_nxt.cache_n = !q_req.cacheable;
          st_nxt.burst = q_req.write && q_req.cacheable;
          st_nxt.beats = '0;
          st_nxt.first_done = 1'b0;
        end else begin
          st_nxt.cycle_pending_req = q_valid;
        end
      end
      CLBI_ADDR: begin
        st_nxt.bus = CLBI_DATA;
        if (st_r.cur.write) begin
          st_nxt.wbuf_block = !ext_wbuf_empty_n_in ? 1'b0 : 1'b1;
        end
        if (done) begin
          st_nxt.bus = CLBI_DATA;
        end
      end
      CLBI_DATA: begin
        // Termination counts only here; one seen in the address state is ignored.
        if (done) begin
          if (!st_r.first_done && st_r.cache_n == 1'b0 && !st_r.wr) begin
            st_nxt.burst = !fill_allow_n_in;
          end
          st_nxt.first_done = 1'b1;
          if (!st_r.wr) begin
            st_nxt.rdat = data_lines_in;
            st_nxt.rvalid = 1'b1;
            st_nxt.perr = byte_par(data_lines_in.value) !=
                          data_lines_in.parity;
          end
          st_nxt.beats = st_r.beats + 3'h1;
          if (!(st_nxt.burst) ||
              st_r.beats == `CLBI_BURST_BEATS - 3'h1) begin
            st_nxt.bus = CLBI_IDLE;
          end
        end
        st_nxt.cycle_pending_req = q_valid;
      end
      default: begin
        st_nxt.bus = CLBI_IDLE;
      end
    endcase
    if (st_r.cur.write && st_r.bus != CLBI_IDLE && !ext_wbuf_empty_n_in) begin
      st_nxt.wbuf_block = 1'b0;
    end
    if (ext_wbuf_empty_n_in == 1'b0) begin
      st_nxt.wbuf_block = 1'b0;
    end
    // Inquiry pipe: strobe refused while dirty hit shows.
    st_nxt.snp_pipe = {st_r.snp_pipe[0],
                       !snoop_strobe_n_in && st_r.dirty_n};
    if (!snoop_strobe_n_in && st_r.dirty_n) begin
      st_nxt.snp.invalidate = snoop_invalidate_in;
    end
    st_nxt.set_inv = 1'b0;
    st_nxt.set_shr = 1'b0;
    if (st_r.snp_pipe[0]) begin
      st_nxt.hit_n = !snoop_line_valid_in;
      st_nxt.dirty_n = !(snoop_line_valid_in && snoop_line_dirty_in);
      st_nxt.set_inv = snoop_line_valid_in && st_r.snp.invalidate;
      st_nxt.set_shr = snoop_line_valid_in && !st_r.snp.invalidate;
    end
    if (!st_r.dirty_n && snoop_done_in) begin
      st_nxt.dirty_n = 1'b1;
    end
    // Flush runs a fixed count; repeats are ignored meanwhile.
    if (st_r.flush_cnt != 8'h00) begin
      st_nxt.flush_cnt = st_r.flush_cnt - 8'h01;
    end else if (!flush_n_in) begin
      st_nxt.flush_cnt = `CLBI_FLUSH_CYCLES;
    end
    st_nxt.fbusy = st_nxt.flush_cnt != 8'h00;
    st_nxt.fp_error_n_n = !(fp_fault_in && fp_fault_unmasked_in);
    // Registered so the stall pin cannot glitch with the ignore input.
    st_nxt.stall = !st_nxt.fp_error_n_n && fp_error_ignore_n_in;
    st_nxt.irq = maskable_irq_in && irq_enable_flag_in &&
                 (st_nxt.flush_cnt == 8'h00);
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
      st_r.ads_n <= 1'b1;
      st_r.cache_n <= 1'b1;
      st_r.hit_n <= 1'b1;
      st_r.dirty_n <= 1'b1;
      st_r.fp_error_n_n <= 1'b1;
      st_r.ratio <= `CLBI_RATIO_2X;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
    end
  end

  assign addr_strobe_n_out = st_r.ads_n;
  assign cycle_pending_req_out = st_r.cycle_pending_req;
  assign cache_flag_n_out = st_r.cache_n;
  assign data_code_out = st_r.dc;
  assign write_read_out = st_r.wr;
  assign line_addr_lines_out = st_r.cur.addr;
  assign addr_parity_out = ^st_r.cur.addr[`CLBI_ADDR_W-1:`CLBI_LINE_LSB];
  assign line_addr_lines_oe_out = !st_r.addr_off && !st_r.hold_ack;
  assign data_lines_out.value = st_r.cur.wdata;
  assign data_lines_out.parity = byte_par(st_r.cur.wdata);
  assign data_lines_oe_out = st_r.wr && st_r.bus == CLBI_DATA &&
                             !st_r.data_off && !st_r.hold_ack;
  assign hold_ack_out = st_r.hold_ack;
  assign snoop_hit_n_out = st_r.hit_n;
  assign snoop_hit_dirty_n_out = st_r.dirty_n;
  assign snoop_set_invalid_out = st_r.set_inv;
  assign snoop_set_shared_out = st_r.set_shr;
  assign core_ratio_out = st_r.ratio;
  assign flush_busy_out = st_r.fbusy;
  assign fp_error_n_out = st_r.fp_error_n_n;
  assign fp_stall_out = st_r.stall;
  assign irq_take_out = st_r.irq;
  assign rd_data_out = st_r.rdat;
  assign rd_valid_out = st_r.rvalid;
  assign rd_par_err_out = st_r.perr;

  AST_ADS_CYCLE_PENDING_REQ: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !addr_strobe_n_out |-> cycle_pending_req_out)
    else $error("request low with strobe");
  AST_HIT_TWO: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    clk_en_in && !snoop_strobe_n_in && snoop_hit_dirty_n_out ##1 clk_en_in
    ##1 clk_en_in |=> snoop_hit_n_out == $past(!snoop_line_valid_in))
    else $error("hit not two clocks after strobe");
  AST_DATA_OE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    data_lines_oe_out |-> write_read_out && !hold_ack_out)
    else $error("data driven outside write");
  AST_DFLOAT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    clk_en_in && data_float_req_in && scatter_enable_in |=> !data_lines_oe_out)
    else $error("data not floated");
  AST_AFLOAT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    clk_en_in && addr_float_req_in |=> !line_addr_lines_oe_out)
    else $error("address not floated");
  AST_IRQ: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    irq_take_out |-> $past(irq_enable_flag_in))
    else $error("interrupt while masked");
  AST_INV: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !(snoop_set_invalid_out && snoop_set_shared_out))
    else $error("line both invalid and shared");
  AST_FLUSH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    flush_busy_out |-> !irq_take_out)
    else $error("interrupt during flush");
  COV_WRITE: cover property (@(posedge ref_clk_in) data_lines_oe_out);
  COV_DIRTY: cover property (@(posedge ref_clk_in) !snoop_hit_dirty_n_out);
  COV_HOLD: cover property (@(posedge ref_clk_in) hold_ack_out);
endmodule

// >>> core/clbi_defs.svh
// Constants for the local bus interface block.
`ifndef CLBI_DEFS_SVH
`define CLBI_DEFS_SVH
`define CLBI_DATA_W 64
`define CLBI_BYTES 8
`define CLBI_ADDR_W 29
`define CLBI_LINE_LSB 2
`define CLBI_BURST_BEATS 3'h4
`define CLBI_HIT_DELAY 2
`define CLBI_FLUSH_CYCLES 8'h40
`define CLBI_FIFO_DEPTH 8
`define CLBI_RATIO_2X 2'h2
`define CLBI_RATIO_3X 2'h3
`endif

// >>> core/clbi_pkg.sv
// Types shared by the local bus interface block.
`include "clbi_defs.svh"
package clbi_pkg;
  typedef enum logic [2:0] {
    CLBI_IDLE = 3'b000,
    CLBI_ADDR = 3'b001,
    CLBI_DATA = 3'b011,
    CLBI_HOLD = 3'b010,
    CLBI_STALL = 3'b110
  } clbi_bus_st_t;

  typedef struct packed {
    logic write;
    logic data_acc;
    logic cacheable;
    logic line_excl;
    logic [`CLBI_ADDR_W-1:0] addr;
    logic [`CLBI_DATA_W-1:0] wdata;
  } clbi_req_t;

  typedef struct packed {
    logic [`CLBI_DATA_W-1:0] value;
    logic [`CLBI_BYTES-1:0] parity;
  } clbi_data_t;

  typedef struct packed {
    logic hit;
    logic dirty;
    logic invalidate;
  } clbi_snoop_t;
endpackage

// >>> core/clbi_fifo.sv
// Request FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module clbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } clbi_fifo_st_t;
  clbi_fifo_st_t st_r;
  clbi_fifo_st_t st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = st_r.wp == st_r.rp;
  assign full = (st_r.wp[AW] != st_r.rp[AW]) &&
                (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem[st_r.rp[AW-1:0]];
  assign push = wr_valid_in && !full && clk_en_in;
  assign pop = rd_ready_in && !empty && clk_en_in;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[st_r.wp[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// >>> tb/clbi_mem_model.sv
// Memory-controller model that terminates bus cycles and returns read data.
`timescale 1ns/1ps
`include "clbi_defs.svh"
module clbi_mem_model
  import clbi_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic addr_strobe_n_in,
  input wire logic write_read_in,
  input wire logic cache_flag_n_in,
  input wire logic [3:0] wait_in,
  input wire logic fill_en_in,
  input wire logic bad_par_in,
  output logic xfer_done_n_out,
  output logic xfer_done_alt_n_out,
  output logic fill_allow_n_out,
  output clbi_data_t data_out
);
  logic [3:0] cnt_r;
  logic [1:0] idx_r;
  logic busy_r, burst_r, rd_r, cache_r, fill_now;
  clbi_data_t rd;

  always_comb begin
    rd.value = 64'h0123_4567_89ab_cdef + {62'h0, idx_r};
    for (int b = 0; b < 8; b++) rd.parity[b] = ^rd.value[8*b +: 8];
    rd.parity[0] = rd.parity[0] ^ bad_par_in;
  end
  assign fill_now = idx_r == 2'h0 && rd_r && cache_r && fill_en_in;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {busy_r, burst_r, rd_r, cache_r} <= 4'h0;
      cnt_r <= 4'h0;
      idx_r <= 2'h0;
      {xfer_done_n_out, xfer_done_alt_n_out, fill_allow_n_out} <= 3'h7;
      data_out <= '1;
    end else begin
      {xfer_done_n_out, xfer_done_alt_n_out, fill_allow_n_out} <= 3'h7;
      // Released lines never keep their last value.
      data_out <= ~data_out;
      if (!addr_strobe_n_in) begin
        busy_r <= 1'b1;
        burst_r <= 1'b0;
        cnt_r <= wait_in;
        idx_r <= 2'h0;
        rd_r <= !write_read_in;
        cache_r <= !cache_flag_n_in;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        // Odd beats end on the secondary termination line.
        if (idx_r[0]) xfer_done_alt_n_out <= 1'b0;
        else xfer_done_n_out <= 1'b0;
        if (rd_r) data_out <= rd;
        // Fill permission rides with the first termination.
        if (fill_now) fill_allow_n_out <= 1'b0;
        if (fill_now) burst_r <= 1'b1;
        idx_r <= idx_r + 2'h1;
        busy_r <= (fill_now || burst_r) && idx_r != 2'h3;
      end
    end
  end
endmodule

// >>> tb/tb_clbi_bus_if.sv
// Self-checking bench for the local bus interface block.
`timescale 1ns/1ps
`include "clbi_defs.svh"
module tb_clbi_bus_if
  import clbi_pkg::*;
;
  logic ref_clk_in, sys_rst_in, clk_en_in, req_valid_in, req_ready_out;
  clbi_req_t req_in;
  clbi_data_t rd_data_out, data_lines_out, data_lines_in, p_data;
  logic rd_valid_out, rd_par_err_out, addr_strobe_n_out;
  logic cycle_pending_req_out, cache_flag_n_out, data_code_out;
  logic write_read_out, xfer_done_n_in, xfer_done_alt_n_in, fill_allow_n_in;
  logic ext_wbuf_empty_n_in, line_addr_lines_oe_out, addr_parity_out;
  logic [28:0] line_addr_lines_out, line_addr_lines_in;
  logic [28:0] s_addr = 29'h0aa_5555;
  logic addr_parity_in, addr_float_req_in, data_lines_oe_out;
  logic data_float_req_in, scatter_enable_in, hold_req_in, hold_ack_out;
  logic snoop_strobe_n_in, snoop_invalidate_in, snoop_line_valid_in;
  logic snoop_line_dirty_in, snoop_hit_n_out, snoop_hit_dirty_n_out;
  logic snoop_set_invalid_out, snoop_set_shared_out, snoop_done_in;
  logic core_ratio_sel_in, flush_n_in, flush_busy_out, fp_fault_in;
  logic fp_fault_unmasked_in, fp_error_n_out, fp_error_ignore_n_in;
  logic fp_stall_out, maskable_irq_in, irq_enable_flag_in, irq_take_out;
  logic [1:0] core_ratio_out;
  logic [3:0] p_wait;
  logic fill_en, bad_par;
  int fails, cmp_count, inv_n, sh_n, i;

  clbi_bus_if clbi_bus_if_inst (
    .ref_clk_in, .sys_rst_in, .clk_en_in, .req_in, .req_valid_in,
    .req_ready_out, .rd_data_out, .rd_valid_out, .rd_par_err_out,
    .addr_strobe_n_out, .cycle_pending_req_out, .cache_flag_n_out,
    .data_code_out, .write_read_out, .xfer_done_n_in, .xfer_done_alt_n_in,
    .fill_allow_n_in, .ext_wbuf_empty_n_in, .line_addr_lines_out,
    .line_addr_lines_oe_out, .line_addr_lines_in, .addr_parity_out,
    .addr_parity_in, .addr_float_req_in, .data_lines_out, .data_lines_oe_out,
    .data_lines_in, .data_float_req_in, .scatter_enable_in, .hold_req_in,
    .hold_ack_out, .snoop_strobe_n_in, .snoop_invalidate_in,
    .snoop_line_valid_in, .snoop_line_dirty_in, .snoop_hit_n_out,
    .snoop_hit_dirty_n_out, .snoop_set_invalid_out, .snoop_set_shared_out,
    .snoop_done_in, .core_ratio_sel_in, .core_ratio_out, .flush_n_in,
    .flush_busy_out, .fp_fault_in, .fp_fault_unmasked_in, .fp_error_n_out,
    .fp_error_ignore_n_in, .fp_stall_out, .maskable_irq_in,
    .irq_enable_flag_in, .irq_take_out);

  clbi_mem_model clbi_mem_model_inst (
    .ref_clk_in, .sys_rst_in, .addr_strobe_n_in(addr_strobe_n_out),
    .write_read_in(write_read_out), .cache_flag_n_in(cache_flag_n_out),
    .wait_in(p_wait), .fill_en_in(fill_en), .bad_par_in(bad_par),
    .xfer_done_n_out(xfer_done_n_in), .xfer_done_alt_n_out(xfer_done_alt_n_in),
    .fill_allow_n_out(fill_allow_n_in), .data_out(p_data));

  // Shared wires: whoever enables drives, the other side sees the result.
  assign data_lines_in = data_lines_oe_out ? data_lines_out : p_data;
  assign line_addr_lines_in = line_addr_lines_oe_out ? line_addr_lines_out
                                                     : s_addr;
  assign addr_parity_in = line_addr_lines_oe_out ? addr_parity_out : ^s_addr;

  always @(negedge ref_clk_in) if (snoop_strobe_n_in) s_addr <= ~s_addr;
  always @(posedge ref_clk_in) begin
    if (snoop_set_invalid_out === 1'b1) inv_n++;
    if (snoop_set_shared_out === 1'b1) sh_n++;
  end

  initial begin
    ref_clk_in = 0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  function automatic logic [7:0] epar(input logic [63:0] v);
    for (int b = 0; b < 8; b++) epar[b] = ^v[8*b +: 8];
  endfunction
  task automatic wait_as;
    for (i = 0; i < 40 && addr_strobe_n_out !== 1'b0; i++) tick(1);
    chk("strobe", 0, addr_strobe_n_out);
    if (addr_strobe_n_out !== 1'b0) wrap_up();
  endtask
  task automatic push(input logic w, c, input logic [63:0] d);
    req_in = '{w, 1'b1, c, 1'b0, 29'h0ab_cdef, d};
    req_valid_in = 1;
    for (i = 0; i < 40 && req_ready_out !== 1'b1; i++) tick(1);
    chk("ready", 1, req_ready_out);
    if (req_ready_out !== 1'b1) wrap_up();
    tick(1);
    req_valid_in = 0;
  endtask
  // The s_addr address and parity hold for the whole strobe clock; they reach the wires only while the interface floats its address.
  task automatic snoop(input logic snoop_invalidate, v, d);
    snoop_strobe_n_in = 0;
    snoop_invalidate_in = snoop_invalidate;
    tick(1);
    snoop_strobe_n_in = 1;
    snoop_line_valid_in = v;
    snoop_line_dirty_in = d;
    tick(2);
  endtask
  task automatic do_reset(input logic sel);
    core_ratio_sel_in = sel;
    sys_rst_in = 1;
    tick(8);
    sys_rst_in = 0;
    tick(2);
    chk("ratio", sel ? `CLBI_RATIO_3X : `CLBI_RATIO_2X, core_ratio_out);
    chk("idle_strobe", 1, addr_strobe_n_out);
  endtask

  task automatic t_write;
    p_wait = 4'h3;
    push(1, 0, 64'hfedc_ba98_7654_3210);
    wait_as();
    chk("cycle_pending_req", 1, cycle_pending_req_out);
    chk("dc", 1, data_code_out);
    chk("wr", 1, write_read_out);
    tick(1);
    chk("d_oe", 1, data_lines_oe_out);
    chk("wdata", 64'hfedc_ba98_7654_3210, data_lines_out.value);
    chk("wpar", epar(64'hfedc_ba98_7654_3210), data_lines_out.parity);
    addr_float_req_in = 1;
    data_float_req_in = 1;
    tick(2);
    chk("a_float", 0, line_addr_lines_oe_out);
    chk("d_float", 0, data_lines_oe_out);
    tick(6);
    addr_float_req_in = 0;
    push(1, 0, 64'h0);
    wait_as();
    tick(1);
    chk("d_float2", 0, data_lines_oe_out);
    data_float_req_in = 0;
    for (i = 0; i < 20 && cycle_pending_req_out !== 1'b0; i++) tick(1);
    chk("cycle_pending_req_end", 0, cycle_pending_req_out);
    p_wait = 4'h0;
    tick(8);
  endtask

  task automatic t_read(input logic fill, bad, input int beats);
    int n;
    n = 0;
    fill_en = fill;
    bad_par = bad;
    push(0, 1, 64'h0);
    wait_as();
    chk("cflag", 0, cache_flag_n_out);
    for (int k = 0; k < 30; k++) begin
      if (rd_valid_out === 1'b1) begin
        chk("rdata", 64'h0123_4567_89ab_cdef + n, rd_data_out.value);
        chk("perr", bad, rd_par_err_out);
        n++;
      end
      tick(1);
    end
    chk("beats", beats, n);
    bad_par = 0;
  endtask

  task automatic t_snoop;
    int a, b;
    a = inv_n;
    b = sh_n;
    snoop(1, 1, 0);
    chk("hit", 0, snoop_hit_n_out);
    chk("snoop_hit_dirty_n", 1, snoop_hit_dirty_n_out);
    tick(3);
    chk("hit_held", 0, snoop_hit_n_out);
    snoop(0, 1, 1);
    chk("snoop_hit_dirty_n_on", 0, snoop_hit_dirty_n_out);
    snoop(0, 0, 0);
    chk("refused", 0, snoop_hit_n_out);
    chk("inv_cnt", a + 1, inv_n);
    chk("sh_cnt", b + 1, sh_n);
    snoop_done_in = 1;
    tick(1);
    snoop_done_in = 0;
    tick(3);
    chk("snoop_hit_dirty_n_off", 1, snoop_hit_dirty_n_out);
    snoop(0, 0, 0);
    chk("miss", 1, snoop_hit_n_out);
  endtask

  task automatic t_fp;
    fp_fault_in = 1;
    fp_fault_unmasked_in = 1;
    tick(2);
    chk("fp_error_n", 0, fp_error_n_out);
    chk("stall", 1, fp_stall_out);
    fp_error_ignore_n_in = 0;
    tick(1);
    chk("ignored", 0, fp_stall_out);
    {fp_fault_in, fp_fault_unmasked_in} = 2'h0;
    fp_error_ignore_n_in = 1;
    tick(2);
  endtask

  task automatic t_hold;
    int a;
    // The other master keeps its request up for its whole tenure.
    hold_req_in = 1;
    for (i = 0; i < 20 && hold_ack_out !== 1'b1; i++) tick(1);
    chk("hold_ack", 1, hold_ack_out);
    a = inv_n;
    snoop(1, 1, 0);
    chk("hold_inv", a + 1, inv_n);
    t_fp();
    push(1, 0, 64'h0);
    repeat (4) begin
      tick(1);
      chk("no_strobe", 1, addr_strobe_n_out);
    end
    chk("cycle_pending_req_hold", 1, cycle_pending_req_out);
    hold_req_in = 0;
    wait_as();
    chk("hold_ack_off", 0, hold_ack_out);
    tick(8);
  endtask

  task automatic t_flush;
    int n;
    n = 0;
    maskable_irq_in = 1;
    tick(4);
    chk("irq_masked", 0, irq_take_out);
    flush_n_in = 0;
    tick(1);
    flush_n_in = 1;
    irq_enable_flag_in = 1;
    for (i = 0; i < 9 && flush_busy_out !== 1'b1; i++) tick(1);
    for (int k = 0; k < 200 && flush_busy_out === 1'b1; k++) begin
      flush_n_in = !(k == 10);
      if (k == 20) chk("irq_flush", 0, irq_take_out);
      n++;
      tick(1);
    end
    chk("flush_len", `CLBI_FLUSH_CYCLES, n);
    for (i = 0; i < 8 && irq_take_out !== 1'b1; i++) tick(1);
    chk("irq", 1, irq_take_out);
    maskable_irq_in = 0;
    tick(4);
  endtask

  initial begin
    sys_rst_in = 1;
    {clk_en_in, scatter_enable_in, flush_n_in, snoop_strobe_n_in} = 4'hf;
    fp_error_ignore_n_in = 1;
    {req_valid_in, addr_float_req_in, data_float_req_in, hold_req_in,
     snoop_invalidate_in, snoop_line_valid_in, snoop_line_dirty_in,
     snoop_done_in, fp_fault_in, fp_fault_unmasked_in, maskable_irq_in,
     irq_enable_flag_in, fill_en, bad_par, ext_wbuf_empty_n_in} = '0;
    req_in = '0;
    p_wait = 4'h0;
    do_reset(0);
    t_write();
    t_read(1, 0, `CLBI_BURST_BEATS);
    t_read(0, 1, 1);
    t_snoop();
    t_hold();
    t_flush();
    do_reset(1);
    wrap_up();
  end
endmodule
